// >>> rtl/iosd_decoder.sv
// I/O space decoder and lower register map for the core's peripherals.
// Assumes the core drives one request per cycle, synchronous to clock.
`timescale 1ns/1ns
module iosd_decoder
  import iosd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire iosd_req_t req,
  input wire iosd_evt_t evt,
  input wire iosd_sts_t sts,
  input wire logic [7:0] ext_rdata,
  output iosd_rsp_t rsp_q,
  output iosd_ext_t ext_q,
  output logic ready_q,
  output iosd_port_t port_q,
  output logic [IOSD_SPAN*8-1:0] io_image
);

  ////////////////////////////////////////////////////////////////////////
  // Per-address field decode

  // Bits that software may read and write
  function automatic logic [7:0] rw_mask(input logic [5:0] a);
    case (a)
      IOSD_PORT_A_DIRECTION, IOSD_PORT_A_OUTPUT, IOSD_PORT_B_DIRECTION,
      IOSD_PORT_B_OUTPUT, IOSD_GENERAL_SCRATCH_ZERO, IOSD_NVM_DATA,
      IOSD_NVM_ADDRESS_LOW, IOSD_TIMER8_COUNT, IOSD_TIMER8_COMPARE,
      IOSD_GENERAL_SCRATCH_ONE, IOSD_GENERAL_SCRATCH_TWO,
      IOSD_SERIAL_PERIPH_CONTROL, IOSD_SERIAL_PERIPH_DATA,
      IOSD_DEBUG_LINK_DATA: rw_mask = IOSD_FULL;
      IOSD_PORT_PULLUP_BREAKBEFORE_CTRL: rw_mask = IOSD_PORT_PULLUP_BREAKBEFORE_CTRL_RW;
      IOSD_EXT_IRQ_MASK: rw_mask = IOSD_PAIR_FLAGS;
      IOSD_NVM_ADDRESS_HIGH: rw_mask = IOSD_NVM_HIGH_RW;
      IOSD_TIMER_PRESCALER_SYNC_CTRL: rw_mask = IOSD_TIMER_PRESCALER_SYNC_CTRL_RW;
      IOSD_TIMER8_CONTROL_A: rw_mask = IOSD_TCCRA_RW;
      IOSD_TIMER8_CONTROL_B: rw_mask = IOSD_TCCRB_RW;
      IOSD_SERIAL_PERIPH_STATUS: rw_mask = IOSD_SERIAL_PERIPH_STATUS_RW;
      IOSD_COMPARATOR_CTRL_STATUS: rw_mask = IOSD_COMPARATOR_CTRL_STATUS_RW;
      IOSD_SLEEP_CONTROL: rw_mask = IOSD_SLEEP_CONTROL_RW;
      default: rw_mask = IOSD_NONE;
    endcase
  endfunction

  // Hardware-set flags that clear on a written one
  function automatic logic [7:0] w1c_mask(input logic [5:0] a);
    case (a)
      IOSD_TIMER8_FLAGS: w1c_mask = IOSD_T8_FLAGS;
      IOSD_TIMER16_FLAGS: w1c_mask = IOSD_T16_FLAGS;
      IOSD_PIN_CHANGE_FLAGS, IOSD_EXT_IRQ_FLAGS: w1c_mask = IOSD_PAIR_FLAGS;
      IOSD_COMPARATOR_CTRL_STATUS: w1c_mask = IOSD_COMPARATOR_CTRL_STATUS_FLAG;
      default: w1c_mask = IOSD_NONE;
    endcase
  endfunction

  // Flag events routed to their register
  function automatic logic [7:0] hw_set(input logic [5:0] a,
                                        input iosd_evt_t e);
    case (a)
      IOSD_TIMER8_FLAGS: hw_set = {6'h00, e.t8};
      IOSD_TIMER16_FLAGS: hw_set = {2'h0, e.t16[3], 2'h0, e.t16[2:0]};
      IOSD_PIN_CHANGE_FLAGS: hw_set = {6'h00, e.pc};
      IOSD_EXT_IRQ_FLAGS: hw_set = {6'h00, e.irq};
      IOSD_COMPARATOR_CTRL_STATUS: hw_set = {3'h0, e.aci, 4'h0};
      default: hw_set = IOSD_NONE;
    endcase
  endfunction

  // Read-only status bits from outside the bank
  function automatic logic [7:0] ro_bits(input logic [5:0] a,
                                         input iosd_sts_t s);
    ro_bits = IOSD_NONE;
    case (a)
      IOSD_PORT_A_PIN_INPUT: ro_bits = s.pin_a;
      IOSD_PORT_B_PIN_INPUT: ro_bits = s.pin_b;
      IOSD_SERIAL_PERIPH_STATUS:
        ro_bits[IOSD_SERIAL_PERIPH_STATUS_FLAG_LSB +: 2] = s.spi_flags;
      IOSD_COMPARATOR_CTRL_STATUS: ro_bits[IOSD_ACO_BIT] = s.comp_out;
      default: ro_bits = IOSD_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Request decode

  logic [7:0] regs_q [IOSD_SPAN];
  logic [7:0] regs_d [IOSD_SPAN];
  logic [7:0] rd_arr [IOSD_SPAN];
  iosd_state_t state_q;
  iosd_state_t state_d;

  wire logic take = req.valid & ready_q;
  wire logic op_io = (req.op == IOSD_OP_IN) | (req.op == IOSD_OP_OUT);
  wire logic op_ds = (req.op == IOSD_OP_LOAD) | (req.op == IOSD_OP_STORE);
  wire logic op_bit = (req.op == IOSD_OP_SET_BIT) |
                      (req.op == IOSD_OP_CLR_BIT);
  wire logic op_skip = (req.op == IOSD_OP_SKIP_SET) |
                       (req.op == IOSD_OP_SKIP_CLR);
  wire logic op_wr = (req.op == IOSD_OP_OUT) | (req.op == IOSD_OP_STORE) |
                     op_bit;
  // Direct I/O window
  wire logic io_ok = op_io & (req.addr <= IOSD_IO_TOP);
  // Bit-addressable window
  wire logic bit_ok = (op_bit | op_skip) &
                      (req.addr <= IOSD_BIT_TOP);
  // Data-space mirror of the I/O window
  wire logic mir_hit = op_ds & (req.addr >= IOSD_MIRROR_OFS) &
                       (req.addr < IOSD_EXT_LO);
  // Extended region, data-space kinds only
  wire logic ext_hit = op_ds & (req.addr >= IOSD_EXT_LO) &
                       (req.addr <= IOSD_EXT_HI);
  wire logic io_hit = io_ok | bit_ok | mir_hit;
  wire logic [15:0] mir_addr = req.addr - IOSD_MIRROR_OFS;
  wire logic [5:0] idx = mir_hit ? mir_addr[5:0] : req.addr[5:0];
  wire logic [7:0] bit_1h = 8'h01 << req.bit_sel;
  // Bit operations touch one lane only
  wire logic [7:0] wmask = op_bit ? bit_1h : IOSD_FULL;
  wire logic [7:0] wval = (req.op == IOSD_OP_SET_BIT) ? bit_1h :
                          (req.op == IOSD_OP_CLR_BIT) ? IOSD_NONE :
                          req.wdata;
  wire logic wr_hit = take & io_hit & op_wr;
  wire logic [7:0] rd_val = rd_arr[idx];
  wire logic bit_val = rd_val[req.bit_sel];
  wire logic skip_res = (req.op == IOSD_OP_SKIP_SET) ? bit_val :
                        ~bit_val;

  ////////////////////////////////////////////////////////////////////////
  // Register bank next state

  // Write, flag clear and flag set per location; set wins over clear
  always_comb begin
    logic [7:0] wr;
    logic [7:0] rwm;
    logic [7:0] w1m;
    wr = IOSD_NONE;
    rwm = IOSD_NONE;
    w1m = IOSD_NONE;
    for (int i = 0; i < IOSD_SPAN; i++) begin
      rwm = rw_mask(6'(i));
      w1m = w1c_mask(6'(i));
      wr = (wr_hit && idx == 6'(i)) ? wmask : IOSD_NONE;
      regs_d[i] = (regs_q[i] & ~(wr & rwm)) | (wval & wr & rwm);
      regs_d[i] = regs_d[i] & ~(wr & wval & w1m);
      regs_d[i] = (regs_d[i] | hw_set(6'(i), evt)) & (rwm | w1m);
      rd_arr[i] = (regs_q[i] & (rwm | w1m)) | ro_bits(6'(i), sts);
      io_image[i*8 +: 8] = regs_q[i];
    end
  end

  // Bank storage
  always_ff @(posedge clock) begin
    for (int i = 0; i < IOSD_SPAN; i++) begin
      regs_q[i] <= rst_b ? regs_d[i] : IOSD_RESET_VAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Extended access sequencing

  // One wait cycle while the extended region answers
  always_comb begin
    case (state_q)
      IOSD_ST_IDLE: state_d = (take & ext_hit) ? IOSD_ST_EXT : IOSD_ST_IDLE;
      IOSD_ST_EXT: state_d = IOSD_ST_IDLE;
      default: state_d = IOSD_ST_IDLE;
    endcase
  end

  // State, ready and extended strobe
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= IOSD_ST_IDLE;
      ready_q <= 1'b0;
      ext_q <= '0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == IOSD_ST_IDLE);
      ext_q.valid <= take & ext_hit;
      ext_q.write <= req.op == IOSD_OP_STORE;
      ext_q.addr <= req.addr[7:0];
      ext_q.wdata <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer to the core

  // Reads of reserved space return zero via the masks
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rsp_q <= '0;
    end else if (state_q == IOSD_ST_EXT) begin
      rsp_q.valid <= 1'b1;
      rsp_q.refused <= 1'b0;
      rsp_q.skip <= 1'b0;
      rsp_q.rdata <= ext_q.write ? IOSD_NONE : ext_rdata;
    end else begin
      rsp_q.valid <= take & ~ext_hit;
      rsp_q.refused <= take & ~io_hit & ~ext_hit;
      rsp_q.skip <= take & bit_ok & op_skip & skip_res;
      rsp_q.rdata <= (take & io_hit & ~op_wr & ~op_skip) ? rd_val :
                     IOSD_NONE;
    end
  end

  // Port drive image
  always_ff @(posedge clock) begin
    port_q.dir_a <= rst_b ? regs_d[IOSD_PORT_A_DIRECTION] : IOSD_RESET_VAL;
    port_q.out_a <= rst_b ? regs_d[IOSD_PORT_A_OUTPUT] : IOSD_RESET_VAL;
    port_q.dir_b <= rst_b ? regs_d[IOSD_PORT_B_DIRECTION] : IOSD_RESET_VAL;
    port_q.out_b <= rst_b ? regs_d[IOSD_PORT_B_OUTPUT] : IOSD_RESET_VAL;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Snapshot of the request for multi-cycle checks
  logic [5:0] h_idx_q;
  logic [7:0] h_rd_q;
  logic [7:0] h_keep_q;
  logic [7:0] h_flag_q;
  logic [7:0] h_set_q;
  logic [7:0] h_w1z_q;
  always_ff @(posedge clock) begin
    h_idx_q <= idx;
    h_set_q <= hw_set(idx, evt);
    h_w1z_q <= rd_arr[idx] & w1c_mask(idx) & ~(wval & wmask);
    h_rd_q <= rd_val;
    h_keep_q <= rd_arr[idx] & ~wmask & rw_mask(idx);
    h_flag_q <= wval & wmask & w1c_mask(idx) & ~hw_set(idx, evt);
  end

  sequence s_ext_take;
    take && ext_hit;
  endsequence
  sequence s_ext_answer;
    ext_q.valid && !ready_q ##1 rsp_q.valid;
  endsequence

  a_io_range_out: assert property (@(posedge clock) disable iff (!rst_b)
    take && op_io && req.addr > IOSD_IO_TOP |=> rsp_q.refused)
    else $error("IN/OUT beyond the I/O window was not refused");
  a_mirror_read: assert property (@(posedge clock) disable iff (!rst_b)
    take && mir_hit && req.op == IOSD_OP_LOAD
    |=> rsp_q.rdata == h_rd_q && !rsp_q.refused)
    else $error("Mirrored load returned wrong data");
  a_ext_sequence: assert property (@(posedge clock) disable iff (!rst_b)
    s_ext_take |=> s_ext_answer)
    else $error("Extended access did not strobe then answer");
  a_ext_no_io: assert property (@(posedge clock) disable iff (!rst_b)
    take && op_io |=> !ext_q.valid)
    else $error("IN/OUT reached the extended region");
  a_bit_range: assert property (@(posedge clock) disable iff (!rst_b)
    take && op_bit && req.addr > IOSD_BIT_TOP
    |=> rsp_q.refused && $stable(io_image))
    else $error("Bit operation above 0x1f took effect");
  a_skip_value: assert property (@(posedge clock) disable iff (!rst_b)
    take && bit_ok && req.op == IOSD_OP_SKIP_SET
    |=> rsp_q.skip == h_rd_q[$past(req.bit_sel)])
    else $error("Skip result does not follow the tested bit");
  a_flag_clear: assert property (@(posedge clock) disable iff (!rst_b)
    wr_hit |=> (regs_q[h_idx_q] & h_flag_q) == IOSD_NONE)
    else $error("Flag written with one was not cleared");
  a_bit_only: assert property (@(posedge clock) disable iff (!rst_b)
    wr_hit && op_bit
    |=> (regs_q[h_idx_q] & rw_mask(h_idx_q) & ~$past(wmask))
        == h_keep_q)
    else $error("Bit operation disturbed other bits");
  a_nvm_top_bits: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 (regs_q[IOSD_NVM_ADDRESS_HIGH] & ~IOSD_NVM_HIGH_RW)
        == IOSD_NONE)
    else $error("NVM address bits above the top bit were kept");
  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_b)
    take && io_ok && req.op == IOSD_OP_IN &&
    (rw_mask(idx) | w1c_mask(idx)) == IOSD_NONE && idx > IOSD_PORT_B_OUTPUT
    |=> rsp_q.rdata == IOSD_NONE)
    else $error("Reserved address read non-zero");

  // Flag handling: set beats clear, zeros leave flags alone
  a_set_wins: assert property (@(posedge clock) disable iff (!rst_b)
    wr_hit && hw_set(idx, evt) != IOSD_NONE
    |=> (regs_q[h_idx_q] & h_set_q) == h_set_q)
    else $error("Flag set lost against a same-cycle clear");
  a_zero_keeps: assert property (@(posedge clock) disable iff (!rst_b)
    wr_hit |=> (regs_q[h_idx_q] & h_w1z_q) == h_w1z_q)
    else $error("Flag not written with one was lost");

  // Ready timing after extended and other accesses, strobe timing of the extended region
  a_ready_drop: assert property (@(posedge clock) disable iff (!rst_b)
    take && ext_hit |=> !ready_q ##1 ready_q)
    else $error("Ready did not drop for exactly one cycle");
  a_ready_io: assert property (@(posedge clock) disable iff (!rst_b)
    take && !ext_hit |=> ready_q)
    else $error("Ready dropped after an I/O access");
  a_ext_pulse: assert property (@(posedge clock) disable iff (!rst_b)
    ext_q.valid |=> !ext_q.valid)
    else $error("Extended strobe held longer than one cycle");
  a_ext_addr: assert property (@(posedge clock) disable iff (!rst_b)
    take && ext_hit |=> ext_q.addr == $past(req.addr[7:0]))
    else $error("Extended strobe carries the wrong address");

  // Writes through both windows land at the decoded location
  a_mirror_write: assert property (@(posedge clock) disable iff (!rst_b)
    take && mir_hit && req.op == IOSD_OP_STORE && rw_mask(idx) == IOSD_FULL
    |=> regs_q[h_idx_q] == $past(req.wdata))
    else $error("Mirrored store did not land");
  a_io_write: assert property (@(posedge clock) disable iff (!rst_b)
    take && io_ok && req.op == IOSD_OP_OUT && rw_mask(idx) == IOSD_FULL
    |=> regs_q[h_idx_q] == $past(req.wdata))
    else $error("OUT did not land");
  a_port_image: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 port_q == {regs_q[IOSD_PORT_A_DIRECTION],
                   regs_q[IOSD_PORT_A_OUTPUT],
                   regs_q[IOSD_PORT_B_DIRECTION],
                   regs_q[IOSD_PORT_B_OUTPUT]})
    else $error("Port image differs from its registers");

  // Refused and reserved accesses leave the bank alone
  a_refused_quiet: assert property (@(posedge clock) disable iff (!rst_b)
    take && !io_hit && !ext_hit && evt == '0
    |=> $stable(io_image) && rsp_q.rdata == IOSD_NONE)
    else $error("Refused access changed state or returned data");
  a_reserved_wr: assert property (@(posedge clock) disable iff (!rst_b)
    take && io_hit && op_wr && evt == '0 &&
    (rw_mask(idx) | w1c_mask(idx)) == IOSD_NONE
    |=> $stable(io_image))
    else $error("Write to a reserved address took effect");

  // Skip results inside and above the bit-addressable window
  a_skip_clear: assert property (@(posedge clock) disable iff (!rst_b)
    take && bit_ok && req.op == IOSD_OP_SKIP_CLR
    |=> rsp_q.skip == !h_rd_q[$past(req.bit_sel)])
    else $error("Skip-if-clear does not follow the tested bit");
  a_skip_range: assert property (@(posedge clock) disable iff (!rst_b)
    take && op_skip && req.addr > IOSD_BIT_TOP
    |=> rsp_q.refused && !rsp_q.skip)
    else $error("Skip above 0x1f was not refused");

endmodule // iosd_decoder

// >>> rtl/iosd_pkg.sv
// I/O space decoder package: offsets, masks, opcodes and carriers.
// Assumes a single core clock domain and an 8-bit register space.
package iosd_pkg;

  // Address space limits
  localparam logic [15:0] IOSD_IO_TOP = 16'h003f;
  localparam logic [15:0] IOSD_BIT_TOP = 16'h001f;
  localparam logic [15:0] IOSD_MIRROR_OFS = 16'h0020;
  localparam logic [15:0] IOSD_EXT_LO = 16'h0060;
  localparam logic [15:0] IOSD_EXT_HI = 16'h00ff;
  localparam int IOSD_SPAN = 64;

  // Register offsets in I/O space
  localparam logic [5:0] IOSD_PORT_A_PIN_INPUT = 6'h00;
  localparam logic [5:0] IOSD_PORT_A_DIRECTION = 6'h01;
  localparam logic [5:0] IOSD_PORT_A_OUTPUT = 6'h02;
  localparam logic [5:0] IOSD_PORT_B_PIN_INPUT = 6'h03;
  localparam logic [5:0] IOSD_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] IOSD_PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] IOSD_PORT_PULLUP_BREAKBEFORE_CTRL = 6'h12;
  localparam logic [5:0] IOSD_TIMER8_FLAGS = 6'h15;
  localparam logic [5:0] IOSD_TIMER16_FLAGS = 6'h16;
  localparam logic [5:0] IOSD_PIN_CHANGE_FLAGS = 6'h1b;
  localparam logic [5:0] IOSD_EXT_IRQ_FLAGS = 6'h1c;
  localparam logic [5:0] IOSD_EXT_IRQ_MASK = 6'h1d;
  localparam logic [5:0] IOSD_GENERAL_SCRATCH_ZERO = 6'h1e;
  localparam logic [5:0] IOSD_NVM_DATA = 6'h20;
  localparam logic [5:0] IOSD_NVM_ADDRESS_LOW = 6'h21;
  localparam logic [5:0] IOSD_NVM_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] IOSD_TIMER_PRESCALER_SYNC_CTRL = 6'h23;
  localparam logic [5:0] IOSD_TIMER8_CONTROL_A = 6'h25;
  localparam logic [5:0] IOSD_TIMER8_CONTROL_B = 6'h26;
  localparam logic [5:0] IOSD_TIMER8_COUNT = 6'h27;
  localparam logic [5:0] IOSD_TIMER8_COMPARE = 6'h28;
  localparam logic [5:0] IOSD_GENERAL_SCRATCH_ONE = 6'h2a;
  localparam logic [5:0] IOSD_GENERAL_SCRATCH_TWO = 6'h2b;
  localparam logic [5:0] IOSD_SERIAL_PERIPH_CONTROL = 6'h2c;
  localparam logic [5:0] IOSD_SERIAL_PERIPH_STATUS = 6'h2d;
  localparam logic [5:0] IOSD_SERIAL_PERIPH_DATA = 6'h2e;
  localparam logic [5:0] IOSD_COMPARATOR_CTRL_STATUS = 6'h30;
  localparam logic [5:0] IOSD_DEBUG_LINK_DATA = 6'h31;
  localparam logic [5:0] IOSD_SLEEP_CONTROL = 6'h33;

  // Field masks of implemented bits
  localparam logic [7:0] IOSD_FULL = 8'hff;
  localparam logic [7:0] IOSD_NONE = 8'h00;
  localparam logic [7:0] IOSD_PORT_PULLUP_BREAKBEFORE_CTRL_RW = 8'h33;
  localparam logic [7:0] IOSD_T8_FLAGS = 8'h03;
  localparam logic [7:0] IOSD_T16_FLAGS = 8'h27;
  localparam logic [7:0] IOSD_PAIR_FLAGS = 8'h03;
  localparam logic [7:0] IOSD_NVM_HIGH_RW = 8'h01;
  localparam logic [7:0] IOSD_TIMER_PRESCALER_SYNC_CTRL_RW = 8'h83;
  localparam logic [7:0] IOSD_TCCRA_RW = 8'hc3;
  localparam logic [7:0] IOSD_TCCRB_RW = 8'h07;
  localparam logic [7:0] IOSD_SERIAL_PERIPH_STATUS_RW = 8'h01;
  localparam logic [7:0] IOSD_COMPARATOR_CTRL_STATUS_RW = 8'hcf;
  localparam logic [7:0] IOSD_COMPARATOR_CTRL_STATUS_FLAG = 8'h10;
  localparam logic [7:0] IOSD_SLEEP_CONTROL_RW = 8'h07;
  localparam logic [7:0] IOSD_RESET_VAL = 8'h00;
  // Bit positions of read-only status and of the comparator flag
  localparam int IOSD_SERIAL_PERIPH_STATUS_FLAG_LSB = 6;
  localparam int IOSD_ACO_BIT = 5;
  localparam int IOSD_ACI_BIT = 4;

  // Core access kinds
  typedef enum logic [2:0] {
    IOSD_OP_IN = 3'h0,
    IOSD_OP_OUT = 3'h1,
    IOSD_OP_LOAD = 3'h2,
    IOSD_OP_STORE = 3'h3,
    IOSD_OP_SET_BIT = 3'h4,
    IOSD_OP_CLR_BIT = 3'h5,
    IOSD_OP_SKIP_SET = 3'h6,
    IOSD_OP_SKIP_CLR = 3'h7
  } iosd_op_t;

  typedef enum logic [1:0] {
    IOSD_ST_IDLE = 2'b00,
    IOSD_ST_EXT = 2'b01
  } iosd_state_t;

  typedef struct packed {
    logic valid;
    iosd_op_t op;
    logic [15:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iosd_req_t;

  typedef struct packed {
    logic valid;
    logic refused;
    logic skip;
    logic [7:0] rdata;
  } iosd_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iosd_ext_t;

  typedef struct packed {
    logic [1:0] t8;
    logic [3:0] t16;
    logic [1:0] pc;
    logic [1:0] irq;
    logic aci;
  } iosd_evt_t;

  typedef struct packed {
    logic [7:0] pin_a;
    logic [7:0] pin_b;
    logic [1:0] spi_flags;
    logic comp_out;
  } iosd_sts_t;

  typedef struct packed {
    logic [7:0] dir_a;
    logic [7:0] out_a;
    logic [7:0] dir_b;
    logic [7:0] out_b;
  } iosd_port_t;

endpackage

// >>> bench/iosd_core_model.sv
// Core-side model: issues one access at a time, serves the extended region.
// Assumes the decoder takes on ready_q and pulses rsp_q for one cycle.
`timescale 1ns/1ns
module iosd_core_model
  import iosd_pkg::*;
(
  input wire logic clock,
  input wire logic ready_q,
  input wire iosd_rsp_t rsp_q,
  input wire iosd_ext_t ext_q,
  output iosd_req_t req,
  output logic [7:0] ext_rdata
);
  logic [7:0] junk_q = 8'h0f;
  logic [7:0] st_addr_q = 8'h00;
  logic [7:0] st_data_q = 8'h00;
  int n_ext = 0;

  initial req = '0;

  //////////////////////////////////////////////////////////////////////////
  // Read data only while strobed; a moving pattern otherwise
  assign ext_rdata = (ext_q.valid && !ext_q.write) ?
                     (ext_q.addr ^ 8'h5a) : junk_q;

  // Count strobes and capture extended stores
  always @(posedge clock) begin
    junk_q <= ~junk_q;
    if (ext_q.valid) begin
      n_ext <= n_ext + 1;
      if (ext_q.write) begin
        st_addr_q <= ext_q.addr;
        st_data_q <= ext_q.wdata;
      end
    end
  end

  // Hold the request until taken, release with inverted lines, await answer
  task automatic access(input iosd_op_t k, input logic [15:0] a,
      input logic [2:0] b, input logic [7:0] wd, output iosd_rsp_t r);
    logic taken;
    taken = 1'b0;
    r = '0;
    @(posedge clock);
    req <= '{valid: 1'b1, op: k, addr: a, bit_sel: b, wdata: wd};
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      if (!taken && ready_q) begin
        taken = 1'b1;
        req <= '{valid: 1'b0, op: k, addr: ~a, bit_sel: ~b, wdata: ~wd};
      end
      #1;
      if (taken && rsp_q.valid) begin
        r = rsp_q;
        break;
      end
    end
  endtask
endmodule // iosd_core_model

// >>> bench/iosd_decoder_tb.sv
// Testbench for the I/O space decoder: map, mirror, bit ops and flags.
// Assumes the core model drives requests and serves the extended region.
`timescale 1ns/1ns
module iosd_decoder_tb
  import iosd_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  iosd_req_t req;
  iosd_evt_t evt = '0;
  iosd_sts_t sts = '{pin_a: 8'h3c, pin_b: 8'hc3, spi_flags: 2'b10,
                     comp_out: 1'b1};
  logic [7:0] ext_rdata;
  iosd_rsp_t rsp_q;
  iosd_ext_t ext_q;
  logic ready_q;
  iosd_port_t port_q;
  logic [IOSD_SPAN*8-1:0] io_image;
  iosd_rsp_t r;
  int n_errors = 0;
  int n_tests = 0;
  logic [5:0] rw_a [8] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h1e, 6'h2a,
                           6'h2b, 6'h31};

  always #50 clock = ~clock;

  iosd_decoder uut (.clock(clock), .rst_b(rst_b), .req(req), .evt(evt),
    .sts(sts), .ext_rdata(ext_rdata), .rsp_q(rsp_q), .ext_q(ext_q),
    .ready_q(ready_q), .port_q(port_q), .io_image(io_image));

  iosd_core_model core (.clock(clock), .ready_q(ready_q), .rsp_q(rsp_q),
    .ext_q(ext_q), .req(req), .ext_rdata(ext_rdata));

  //////////////////////////////////////////////////////////////////////////
  // Compare helpers and verdict
  task automatic chk8(input logic [7:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk1(input logic got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One access judged on every answer field
  task automatic io(input iosd_op_t k, input logic [15:0] a,
      input logic [2:0] b, input logic [7:0] wd, er,
      input logic rf, sk);
    core.access(k, a, b, wd, r);
    chk1(r.valid, 1'b1, "answer");
    chk1(r.refused, rf, "refused");
    chk1(r.skip, sk, "skip");
    chk8(r.rdata, er, "rdata");
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io(IOSD_OP_OUT, a, 3'h0, d, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    io(IOSD_OP_IN, a, 3'h0, 8'h00, e, 1'b0, 1'b0);
  endtask

  task automatic bo(input iosd_op_t k, input logic [15:0] a,
      input logic [2:0] b, input logic rf, sk);
    io(k, a, b, 8'h00, 8'h00, rf, sk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_map();
    logic [7:0] d;
    logic [15:0] a;
    rd(16'h001e, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'h5a + 8'(19 * i);
      a = {10'h000, rw_a[i]};
      if (i % 2 == 1)
        io(IOSD_OP_STORE, a + IOSD_MIRROR_OFS, 3'h0, d, 8'h00, 1'b0,
           1'b0);
      else
        wr(a, d);
      rd(a, d);
      io(IOSD_OP_LOAD, a + IOSD_MIRROR_OFS, 3'h0, 8'h00, d, 1'b0,
         1'b0);
      chk8(io_image[8*rw_a[i] +: 8], d, "image");
    end
    chk8(port_q.dir_a, 8'h5a, "dir_a");
    chk8(port_q.out_a, 8'h6d, "out_a");
    chk8(port_q.dir_b, 8'h80, "dir_b");
    chk8(port_q.out_b, 8'h93, "out_b");
    rd(16'h0000, 8'h3c);
    io(IOSD_OP_LOAD, 16'h0023, 3'h0, 8'h00, 8'hc3, 1'b0, 1'b0);
    rd(16'h002d, 8'h80);
    io(IOSD_OP_IN, 16'h0040, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0);
    io(IOSD_OP_LOAD, 16'h001f, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0);
    $display("test map done");
  endtask

  task automatic t_ext();
    int n0;
    n0 = core.n_ext;
    io(IOSD_OP_LOAD, 16'h0080, 3'h0, 8'h00, 8'hda, 1'b0, 1'b0);
    io(IOSD_OP_LOAD, 16'h00ff, 3'h0, 8'h00, 8'ha5, 1'b0, 1'b0);
    io(IOSD_OP_STORE, 16'h0060, 3'h0, 8'h77, 8'h00, 1'b0, 1'b0);
    chk8(core.st_addr_q, 8'h60, "ext addr");
    chk8(core.st_data_q, 8'h77, "ext data");
    io(IOSD_OP_IN, 16'h0060, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0);
    io(IOSD_OP_OUT, 16'h0060, 3'h0, 8'h33, 8'h00, 1'b1, 1'b0);
    io(IOSD_OP_LOAD, 16'h0100, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0);
    chk1(core.n_ext == n0 + 3, 1'b1, "strobes");
    $display("test extended done");
  endtask

  task automatic t_bits();
    wr(16'h001e, 8'ha5);
    bo(IOSD_OP_SET_BIT, 16'h001e, 3'h1, 1'b0, 1'b0);
    bo(IOSD_OP_CLR_BIT, 16'h001e, 3'h0, 1'b0, 1'b0);
    rd(16'h001e, 8'ha6);
    bo(IOSD_OP_SKIP_SET, 16'h001e, 3'h1, 1'b0, 1'b1);
    bo(IOSD_OP_SKIP_SET, 16'h001e, 3'h0, 1'b0, 1'b0);
    bo(IOSD_OP_SKIP_CLR, 16'h001e, 3'h0, 1'b0, 1'b1);
    bo(IOSD_OP_SKIP_CLR, 16'h001e, 3'h7, 1'b0, 1'b0);
    bo(IOSD_OP_SKIP_SET, 16'h0000, 3'h2, 1'b0, 1'b1);
    bo(IOSD_OP_SET_BIT, 16'h0020, 3'h1, 1'b1, 1'b0);
    bo(IOSD_OP_CLR_BIT, 16'h002a, 3'h0, 1'b1, 1'b0);
    bo(IOSD_OP_SKIP_CLR, 16'h003f, 3'h0, 1'b1, 1'b0);
    rd(16'h002a, 8'hb9);
    $display("test bit ops done");
  endtask

  task automatic t_flags();
    @(posedge clock);
    evt <= '{t8: 2'b11, t16: 4'hf, pc: 2'b11, irq: 2'b11, aci: 1'b1};
    @(posedge clock);
    evt <= '0;
    rd(16'h0015, 8'h03);
    wr(16'h0015, 8'h00);
    rd(16'h0015, 8'h03);
    wr(16'h0015, 8'h01);
    rd(16'h0015, 8'h02);
    rd(16'h0016, 8'h27);
    wr(16'h0016, 8'h24);
    rd(16'h0016, 8'h03);
    bo(IOSD_OP_SET_BIT, 16'h001c, 3'h0, 1'b0, 1'b0);
    rd(16'h001c, 8'h02);
    bo(IOSD_OP_CLR_BIT, 16'h001b, 3'h1, 1'b0, 1'b0);
    rd(16'h001b, 8'h03);
    rd(16'h0030, 8'h30);
    wr(16'h0030, 8'h10);
    rd(16'h0030, 8'h20);
    $display("test flags done");
  endtask

  task automatic t_reserved();
    wr(16'h0012, 8'h33);
    rd(16'h0012, 8'h33);
    wr(16'h0012, 8'hff);
    rd(16'h0012, 8'h33);
    wr(16'h000a, 8'hff);
    rd(16'h000a, 8'h00);
    chk8(io_image[8*10 +: 8], 8'h00, "reserved image");
    wr(16'h0022, 8'hff);
    rd(16'h0022, 8'h01);
    wr(16'h0021, 8'hff);
    rd(16'h0021, 8'hff);
    rd(16'h001e, 8'ha6);
    $display("test reserved done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    t_map();
    t_ext();
    t_bits();
    t_flags();
    t_reserved();
    end_sim();
  end

  // Watchdog well beyond the fewer than two hundred cycles the scenarios need
  initial begin
    repeat (4000) @(posedge clock);
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end
endmodule // iosd_decoder_tb
